// ==== common/dap_pkg.sv ====
// shared constants and types for the debug slave port
package dap_pkg;
  localparam int WORD_W = 32;
  localparam int IDX_W = 10;
  localparam int ADDR_IDX_MSB = 11;
  localparam int ADDR_IDX_LSB = 2;
  localparam int SOURCE_BIT = 31;
  localparam logic [31:0] SYSTEM_VIEW_BASE = 32'h0000_0000;
  localparam logic [31:0] DEBUGGER_VIEW_BASE = 32'h8000_0000;
  localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] READ_FILL_VALUE = 32'h0000_0000;
  localparam int DEFAULT_NUM_REGS = 16;
  localparam int DEFAULT_WAIT_STATES = 1;
  localparam int WAIT_W = 4;

  typedef enum logic [1:0] {
    DAP_IDLE = 2'b01,
    DAP_ACCESS = 2'b10
  } dap_state_t;

  // everything arriving from outside the clk_sys domain
  typedef struct packed {
    logic port_clock;
    logic port_clock_enable;
    logic debug_reset_n;
    logic core_powered_up;
    logic port_select;
    logic port_access_phase;
    logic port_write_not_read;
    logic debugger_source_bit;
    logic [IDX_W-1:0] port_address;
    logic [WORD_W-1:0] port_write_data;
  } dap_pins_t;

  // captured request of the transfer in progress
  typedef struct packed {
    logic write;
    logic from_debugger;
    logic [IDX_W-1:0] index;
    logic [WORD_W-1:0] wdata;
  } dap_req_t;
endpackage

// ==== core/dap_slave.sv ====
// debug register file behind a word-only, stallable peripheral slave port
`timescale 1ns/1ps
// What this block does
// - a low debug reset returns every debug register to its reset value.
// - data is 32 bits wide and only whole-word transfers exist.
// - the register is chosen by the ten word-address bits 11 down to 2, a 4KB window.
// - address bits 1 and 0 do not exist on the port since all registers are words.
// - address bit 31 is high for debugger accesses and low for system accesses.
// - the same register set answers at base 0x0 and at base 0x8000_0000.
// - the slave may hold ready low to insert wait states.
// - the error output is valid exactly in the cycle where ready signals completion.
// - an error is returned only when the processor is powered down.
// - the port only advances on rising port-clock edges with the clock enable high.
// - reads return 32 bits of data and writes take 32 bits of data.
module dap_slave #(
  parameter int NUM_REGS = dap_pkg::DEFAULT_NUM_REGS,
  parameter int WAIT_STATES = dap_pkg::DEFAULT_WAIT_STATES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic port_clock,
  input wire logic port_clock_enable,
  input wire logic debug_reset_n,
  input wire logic core_powered_up,
  input wire logic port_select,
  input wire logic port_access_phase,
  input wire logic port_write_not_read,
  input wire logic debugger_source_bit,
  input wire logic [dap_pkg::ADDR_IDX_MSB:dap_pkg::ADDR_IDX_LSB] port_address,
  input wire logic [dap_pkg::WORD_W-1:0] port_write_data,
  output logic [dap_pkg::WORD_W-1:0] port_read_data,
  output logic port_ready,
  output logic port_error,
  output logic access_from_debugger,
  output logic [NUM_REGS-1:0][dap_pkg::WORD_W-1:0] reg_file
);

  localparam logic [dap_pkg::WAIT_W-1:0] WAIT_LOAD = dap_pkg::WAIT_W'(WAIT_STATES);

  dap_pkg::dap_pins_t pins_raw;
  dap_pkg::dap_pins_t sync1_q;
  dap_pkg::dap_pins_t sync2_q;
  dap_pkg::dap_pins_t in_s;
  logic tick;

  dap_pkg::dap_state_t state_q, state_d;
  dap_pkg::dap_req_t req_q, req_d;
  logic [dap_pkg::WAIT_W-1:0] wait_q, wait_d;
  logic ready_q, ready_d;
  logic error_q, error_d;
  logic [dap_pkg::WORD_W-1:0] rdata_q, rdata_d;
  logic [NUM_REGS-1:0][dap_pkg::WORD_W-1:0] regs_q, regs_d;

  logic setup_seen;
  logic complete;
  logic index_hit;

  // address bits 1:0 have no port at all; bit 31 travels separately
  assign pins_raw = '{
    port_clock: port_clock,
    port_clock_enable: port_clock_enable,
    debug_reset_n: debug_reset_n,
    core_powered_up: core_powered_up,
    port_select: port_select,
    port_access_phase: port_access_phase,
    port_write_not_read: port_write_not_read,
    debugger_source_bit: debugger_source_bit,
    port_address: port_address,
    port_write_data: port_write_data
  };

  // two stages against metastability, then one more copy that still shows the pins as they
  // stood before the port clock rose: the master may change them right after that edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      in_s <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      in_s <= sync2_q;
    end
  end

  // only enabled rising port-clock edges move the port; enable is taken before the edge
  assign tick = sync2_q.port_clock & ~in_s.port_clock & in_s.port_clock_enable;

  assign setup_seen = in_s.port_select & ~in_s.port_access_phase;
  assign complete = ready_q & in_s.port_select & in_s.port_access_phase;
  // both views alias one register set; bit 31 never takes part in decode
  assign index_hit = 32'(req_q.index) < NUM_REGS;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    wait_d = wait_q;
    ready_d = ready_q;
    error_d = error_q;
    rdata_d = rdata_q;
    regs_d = regs_q;
    if (tick) begin
      case (state_q)
        dap_pkg::DAP_IDLE: begin
          if (setup_seen) begin
            // capture the request at the setup edge; master holds it stable after
            req_d.write = in_s.port_write_not_read;
            req_d.from_debugger = in_s.debugger_source_bit;
            req_d.index = in_s.port_address;
            req_d.wdata = in_s.port_write_data;
            wait_d = WAIT_LOAD;
            state_d = dap_pkg::DAP_ACCESS;
            if (WAIT_LOAD == '0) begin
              ready_d = 1'b1;
              error_d = ~in_s.core_powered_up;
              rdata_d = dap_pkg::READ_FILL_VALUE;
              if (in_s.core_powered_up && !in_s.port_write_not_read &&
                  32'(in_s.port_address) < NUM_REGS) begin
                rdata_d = regs_q[in_s.port_address];
              end
            end
          end
        end
        dap_pkg::DAP_ACCESS: begin
          if (!in_s.port_select) begin
            // master walked away mid-transfer: drop it quietly
            ready_d = 1'b0;
            error_d = 1'b0;
            state_d = dap_pkg::DAP_IDLE;
          end else if (complete) begin
            if (req_q.write && !error_q && index_hit) begin
              regs_d[req_q.index] = req_q.wdata;
            end
            ready_d = 1'b0;
            error_d = 1'b0;
            state_d = dap_pkg::DAP_IDLE;
          end else if (!ready_q) begin
            // hold ready low until the wait count runs out
            if (wait_q <= dap_pkg::WAIT_W'(1)) begin
              wait_d = '0;
              ready_d = 1'b1;
              // error is produced together with ready, never on its own
              error_d = ~in_s.core_powered_up;
              rdata_d = dap_pkg::READ_FILL_VALUE;
              if (in_s.core_powered_up && !req_q.write && index_hit) begin
                rdata_d = regs_q[req_q.index];
              end
            end else begin
              wait_d = wait_q - dap_pkg::WAIT_W'(1);
            end
          end
        end
        default: begin
          state_d = dap_pkg::DAP_IDLE;
          ready_d = 1'b0;
          error_d = 1'b0;
        end
      endcase
    end
    // debug reset wins over any write in flight
    if (!in_s.debug_reset_n) begin
      regs_d = {NUM_REGS{dap_pkg::REG_RESET_VALUE}};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= dap_pkg::DAP_IDLE;
      req_q <= '0;
      wait_q <= '0;
      ready_q <= 1'b0;
      error_q <= 1'b0;
      rdata_q <= dap_pkg::READ_FILL_VALUE;
      regs_q <= {NUM_REGS{dap_pkg::REG_RESET_VALUE}};
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      wait_q <= wait_d;
      ready_q <= ready_d;
      error_q <= error_d;
      rdata_q <= rdata_d;
      regs_q <= regs_d;
    end
  end

  assign port_ready = ready_q;
  assign port_error = error_q;
  assign port_read_data = rdata_q;
  assign access_from_debugger = req_q.from_debugger;
  assign reg_file = regs_q;

  AST_ERR_WITH_READY: assert property (@(posedge clk_sys) disable iff (!resetn)
    port_error |-> port_ready)
    else $error("error raised without ready");

  AST_ERR_ONLY_POWER_DOWN: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(port_ready) |-> (port_error == !$past(in_s.core_powered_up)))
    else $error("error response does not match power state");

  AST_READY_HOLDS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port_ready && !tick && in_s.port_select) |=> port_ready)
    else $error("ready dropped between port edges");

  AST_ONLY_ON_TICK: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!tick && in_s.debug_reset_n) |=> ($stable(state_q) && $stable(reg_file)))
    else $error("port state moved without an enabled port edge");

  AST_DEBUG_RESET: assert property (@(posedge clk_sys) disable iff (!resetn)
    !in_s.debug_reset_n |=> (reg_file == {NUM_REGS{dap_pkg::REG_RESET_VALUE}}))
    else $error("debug reset did not clear the registers");

  AST_WRITE_LANDS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_ACCESS && complete && req_q.write && !port_error &&
     index_hit && in_s.debug_reset_n) |=> (reg_file[$past(req_q.index)] == $past(req_q.wdata)))
    else $error("completed write not stored");

  AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(port_ready) && !port_error && !req_q.write && index_hit && $stable(reg_file))
      |-> (port_read_data == reg_file[req_q.index]))
    else $error("read data does not match selected register");

  AST_SOURCE_LATCHED: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_IDLE && setup_seen)
      |=> (access_from_debugger == $past(in_s.debugger_source_bit)))
    else $error("access source not captured at setup");

  AST_READY_DROPS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && complete) |=> (!port_ready && state_q == dap_pkg::DAP_IDLE))
    else $error("ready stayed high after completion");

  AST_ERR_STEADY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port_ready && $past(port_ready)) |-> $stable(port_error))
    else $error("error changed while ready stood high");

  AST_RDATA_STEADY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port_ready && $past(port_ready)) |-> $stable(port_read_data))
    else $error("read data changed while ready stood high");

  AST_WRITE_NO_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(port_ready) && req_q.write) |-> (port_read_data == dap_pkg::READ_FILL_VALUE))
    else $error("write answered with read data");

  AST_ERROR_NO_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(port_ready) && port_error) |-> (port_read_data == dap_pkg::READ_FILL_VALUE))
    else $error("aborted read returned register data");

  AST_UNMAPPED_NO_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(port_ready) && !index_hit) |-> (port_read_data == dap_pkg::READ_FILL_VALUE))
    else $error("unmapped read returned data");

  AST_NO_WRITE_ON_ERROR: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && complete && port_error && in_s.debug_reset_n) |=> $stable(reg_file))
    else $error("aborted write changed the registers");

  AST_SOURCE_HELD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == dap_pkg::DAP_ACCESS) |=> $stable(access_from_debugger))
    else $error("access source changed during a transfer");

  AST_IDLE_NOT_READY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == dap_pkg::DAP_IDLE) |-> !port_ready)
    else $error("ready high with no transfer");

  AST_SETUP_WAITS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_IDLE && setup_seen && WAIT_LOAD != '0) |=> !port_ready)
    else $error("ready rose at setup although wait states are set");

  AST_WAIT_COUNTS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_ACCESS && in_s.port_select && !port_ready &&
     wait_q > dap_pkg::WAIT_W'(1)) |=> !port_ready)
    else $error("ready rose before the wait states ran out");

  AST_SETUP_TO_ACCESS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_IDLE && setup_seen)
      |=> (state_q == dap_pkg::DAP_ACCESS))
    else $error("setup edge did not start a transfer");

  AST_ABORT_TO_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_ACCESS && !in_s.port_select)
      |=> (state_q == dap_pkg::DAP_IDLE && !port_ready))
    else $error("dropped select did not end the transfer");

  AST_STATE_ONE_HOT: assert property (@(posedge clk_sys) disable iff (!resetn)
    $onehot(state_q))
    else $error("transfer state lost its one-hot code");

  AST_REQ_CAPTURED: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_IDLE && setup_seen)
      |=> (req_q.index == $past(in_s.port_address) &&
           req_q.write == $past(in_s.port_write_not_read)))
    else $error("address or direction not captured at setup");

  AST_WDATA_CAPTURED: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tick && state_q == dap_pkg::DAP_IDLE && setup_seen)
      |=> (req_q.wdata == $past(in_s.port_write_data)))
    else $error("write data not captured at setup");

  COV_WRITE: cover property (@(posedge clk_sys) disable iff (!resetn)
    tick && complete && req_q.write && !port_error);
  COV_READ: cover property (@(posedge clk_sys) disable iff (!resetn)
    tick && complete && !req_q.write && !port_error);
  COV_ERROR: cover property (@(posedge clk_sys) disable iff (!resetn)
    tick && complete && port_error);
  COV_DEBUGGER_VIEW: cover property (@(posedge clk_sys) disable iff (!resetn)
    tick && complete && access_from_debugger);
  COV_STALLED_EDGE: cover property (@(posedge clk_sys) disable iff (!resetn)
    tick && state_q == dap_pkg::DAP_ACCESS && !port_ready);

endmodule

// ==== tb/dap_master_model.sv ====
// bus master model driving the debug slave port on its own port clock
`timescale 1ns/1ps
module dap_master_model (
  output logic port_clock,
  output logic port_clock_enable,
  output logic port_select,
  output logic port_access_phase,
  output logic port_write_not_read,
  output logic debugger_source_bit,
  output logic [9:0] port_address,
  output logic [31:0] port_write_data,
  input wire logic [31:0] port_read_data,
  input wire logic port_ready,
  input wire logic port_error
);
  int stall_edges = 0;
  logic rdy_s;
  logic err_s;
  logic [31:0] rd_s;
  initial begin
    {port_clock, port_clock_enable, port_select, port_access_phase} = 4'h0;
    {port_write_not_read, debugger_source_bit, port_address} = 12'h000;
    port_write_data = 32'h0000_0000;
  end
  // one port clock period; the answer is taken at the rising edge itself
  task automatic port_edge(input logic en);
    port_clock_enable = en;
    #395 port_clock = 0;
    #400 rdy_s = port_ready;
    rd_s = port_read_data;
    err_s = port_error;
    port_clock = 1;
    #5;
  endtask
  task automatic xfer(input logic wr, input logic dbg, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd, output logic err,
                      output int n_acc);
    int s;
    port_select = 1;
    port_access_phase = 0;
    port_write_not_read = wr;
    debugger_source_bit = dbg;
    port_address = idx;
    port_write_data = wd;
    port_edge(1'b1);
    port_access_phase = 1;
    n_acc = 0;
    rdy_s = 0;
    while (rdy_s !== 1'b1 && n_acc < 20) begin
      for (s = 0; s < stall_edges; s++) port_edge(1'b0);
      n_acc++;
      port_edge(1'b1);
    end
    rd = rd_s;
    err = err_s;
    // released lines must not keep showing the old values
    port_select = 0;
    port_access_phase = 0;
    port_write_not_read = ~wr;
    debugger_source_bit = ~dbg;
    port_address = ~idx;
    port_write_data = ~wd;
    port_clock_enable = 0;
  endtask
endmodule

// ==== tb/dap_slave_bench.sv ====
// self-checking bench for the debug slave port
`timescale 1ns/1ps
module dap_slave_bench;
  localparam int NREG = 16;
  localparam int WS = 2;
  localparam logic [31:0] DW = 32'h1234_5678;
  logic clk_sys, resetn, debug_reset_n, core_powered_up;
  logic port_clock, port_clock_enable, port_select, port_access_phase;
  logic port_write_not_read, debugger_source_bit, port_ready, port_error;
  logic access_from_debugger;
  logic [9:0] port_address;
  logic [31:0] port_write_data, port_read_data, rd;
  logic [NREG-1:0][31:0] reg_file;
  logic er;
  int na, cycles = 0, mismatches = 0, samples_checked = 0;
  dap_slave #(.NUM_REGS(NREG), .WAIT_STATES(WS)) dap_slave_inst (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port_clock(port_clock),
    .port_clock_enable(port_clock_enable),
    .debug_reset_n(debug_reset_n),
    .core_powered_up(core_powered_up),
    .port_select(port_select),
    .port_access_phase(port_access_phase),
    .port_write_not_read(port_write_not_read),
    .debugger_source_bit(debugger_source_bit),
    .port_address(port_address),
    .port_write_data(port_write_data),
    .port_read_data(port_read_data),
    .port_ready(port_ready),
    .port_error(port_error),
    .access_from_debugger(access_from_debugger),
    .reg_file(reg_file)
  );
  dap_master_model dap_master_model_inst (
    .port_clock(port_clock),
    .port_clock_enable(port_clock_enable),
    .port_select(port_select),
    .port_access_phase(port_access_phase),
    .port_write_not_read(port_write_not_read),
    .debugger_source_bit(debugger_source_bit),
    .port_address(port_address),
    .port_write_data(port_write_data),
    .port_read_data(port_read_data),
    .port_ready(port_ready),
    .port_error(port_error)
  );
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    samples_checked++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic xf(input logic wr, dbg, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    #2 dap_master_model_inst.xfer(wr, dbg, idx, wd, rd, er, na);
    // registers and outputs follow the last port edge by about three system cycles
    repeat (4) @(posedge clk_sys);
    #2;
  endtask
  task automatic pins(input logic rn, pw);
    @(posedge clk_sys);
    #2 debug_reset_n = rn;
    core_powered_up = pw;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic t_alias;
    xf(1'b1, 1'b0, 10'h003, DW);
    chk(er, 0);
    chk(na, WS + 1);
    chk(access_from_debugger, 0);
    chk(reg_file[3], DW);
    xf(1'b0, 1'b1, 10'h003, 32'h0000_0000);
    chk(rd, DW);
    chk(access_from_debugger, 1);
    $display("alias test ended");
  endtask
  task automatic t_bounds;
    xf(1'b1, 1'b1, 10'(NREG - 1), 32'hA5A5_0F0F);
    xf(1'b0, 1'b0, 10'(NREG - 1), 32'h0000_0000);
    chk(rd, 32'hA5A5_0F0F);
    xf(1'b1, 1'b0, 10'h3FF, 32'hFFFF_FFFF);
    xf(1'b0, 1'b0, 10'h3FF, 32'h0000_0000);
    chk(rd, 0);
    chk(er, 0);
    $display("bounds test ended");
  endtask
  task automatic t_clken;
    dap_master_model_inst.stall_edges = 2;
    xf(1'b0, 1'b1, 10'h003, 32'h0000_0000);
    chk(na, WS + 1);
    chk(rd, DW);
    dap_master_model_inst.stall_edges = 0;
    $display("clock enable test ended");
  endtask
  task automatic t_power;
    pins(1'b1, 1'b0);
    xf(1'b1, 1'b0, 10'h003, 32'h0000_0000);
    chk(er, 1);
    xf(1'b0, 1'b1, 10'h003, 32'h0000_0000);
    chk(er, 1);
    chk(rd, 0);
    pins(1'b1, 1'b1);
    xf(1'b0, 1'b0, 10'h003, 32'h0000_0000);
    chk(rd, DW);
    chk(er, 0);
    $display("power test ended");
  endtask
  task automatic t_dreset;
    pins(1'b0, 1'b1);
    chk(reg_file[3], 0);
    pins(1'b1, 1'b1);
    xf(1'b0, 1'b1, 10'(NREG - 1), 32'hFFFF_FFFF);
    chk(rd, 0);
    $display("debug reset test ended");
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the tests need well under a thousand cycles; this cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    resetn = 0;
    debug_reset_n = 1;
    core_powered_up = 1;
    repeat (16) @(posedge clk_sys);
    #2 resetn = 1;
    repeat (4) @(posedge clk_sys);
    t_alias();
    t_bounds();
    t_clken();
    t_power();
    t_dreset();
    summarize();
  end
endmodule
